// >>> hw/psc_top.sv
// Pin state controller: pin drive, direction and pull-up control per chip state
// Contract
// - Initialisation low puts all general port pins into input, high impedance.
// - Initialisation drives all four strobes high outside mode 7, floats data bus.
// - Mode 1: address low, direction high 1.5 clocks after initialisation seen.
// - Clock output and bus-sync pins become outputs 0.5 clocks after initialisation.
// - Mode 2 initialisation makes address bits 15 to 8 input ports.
// - Kept address-shared pins keep pull-up on when direction 0, latch 1.
// - Software standby resets peripherals; shared pins stop driving and float.
// - Software standby returns timer pin to port; grant output floats.
// - Sleep accepts bus request, grant driven low through bus release.
// - Sleep: address-configured shared pins low, input pins stay floating.
// - Pull-ups off in initialisation, hardware standby and pure address modes.
// - Elsewhere a mode-enabled pull-up is on only for direction 0, latch 1.
// - Software standby and bus release float shared pins, pull-ups kept.
`timescale 1ns/1ps
module psc_top
    import psc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              chip_init_n,
    input  wire logic              hw_sleep_pin_n,
    input  wire logic              bus_request_in,
    input  wire logic [19:0]       core_addr,
    input  wire logic [3:0]        core_strobe_n,
    input  wire logic              core_rw,
    input  wire logic              core_data_oe,
    input  wire logic              timer_out,
    output logic [3:0]             strobe_n,
    output logic                   strobe_oe,
    output logic                   rw_out,
    output logic                   rw_oe,
    output logic                   data_oe,
    output logic [7:0]             addr_lo_out,
    output logic                   addr_lo_oe,
    output logic [P5_W-1:0]        p5_out,
    output logic [P5_W-1:0]        p5_oe,
    output logic [P5_W-1:0]        p5_pullup,
    output logic [P6_W-1:0]        p6_out,
    output logic [P6_W-1:0]        p6_oe,
    output logic [P6_W-1:0]        p6_pullup,
    output logic                   clk_pins_oe,
    output logic                   clk_hold_high,
    output logic                   grant_out_n,
    output logic                   grant_oe,
    output logic                   timer_pin_out,
    output logic                   timer_pin_oe,
    output logic                   periph_rst,
    output logic                   ports_oe_en,
    output logic [7:0]             p8_oe
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [9:0]           ctrl_ff;
    logic [15:0]          port5_ff;
    logic [15:0]          port6_ff;
    psc_state_t           state_ff;
    psc_state_t           nxt_state;
    logic [CNT_W-1:0]     cnt_ff;
    logic [CNT_W-1:0]     nxt_cnt;
    logic [CNT_W-1:0]     guard_ff;
    logic                 ram_ok_ff;
    logic [2:0]           mode;
    logic                 ext_mode;
    psc_role_t            role5;
    psc_role_t            role6;
    logic                 addr_ok;
    logic                 clk_ok;
    logic                 wr_en;

    assign mode     = ctrl_ff[CTRL_MODE_LSB +: CTRL_MODE_W];
    assign ext_mode = (mode != MODE_7);
    assign wr_en    = psel & penable & pready & pwrite;

    // ************************************************************
    // APB slave: one wait-free access phase after setup
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                if (paddr == PSC_CTRL_OFS)
                    prdata <= {22'h00_0000, ctrl_ff};
                else if (paddr == PSC_PORT5_OFS)
                    prdata <= {16'h0000, port5_ff};
                else if (paddr == PSC_PORT6_OFS)
                    prdata <= {16'h0000, port6_ff};
                else if (paddr == PSC_STATUS_OFS)
                    prdata <= {23'h00_0000, ram_ok_ff, 2'h0, state_ff};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_ff  <= CTRL_RST;
            port5_ff <= 16'h0000;
            port6_ff <= 16'h0000;
        end
        else if (wr_en)
        begin
            if (paddr == PSC_CTRL_OFS)
                ctrl_ff <= pwdata[9:0];
            else if (paddr == PSC_PORT5_OFS)
                port5_ff <= pwdata[15:0];
            else if (paddr == PSC_PORT6_OFS)
                port6_ff <= {4'h0, pwdata[11:8], 4'h0, pwdata[3:0]};
        end
    end

    // ************************************************************
    // Chip state sequencing
    // ************************************************************
    always_comb
    begin
        nxt_state = ST_RUN;
        if (!hw_sleep_pin_n)
            nxt_state = ST_HWSTBY;
        else if (!chip_init_n)
            nxt_state = ST_INIT;
        else if (state_ff == ST_INIT || state_ff == ST_HWSTBY)
            nxt_state = ST_RUN;
        else if (bus_request_in && ctrl_ff[CTRL_GRANT_BIT] && ext_mode
                 && (state_ff == ST_RUN || state_ff == ST_SLEEP || state_ff == ST_BUSREL))
            nxt_state = ST_BUSREL;
        else if (ctrl_ff[CTRL_SWSTB_BIT])
            nxt_state = ST_SWSTBY;
        else if (ctrl_ff[CTRL_SLEEP_BIT])
            nxt_state = ST_SLEEP;
        nxt_cnt = '0;
        if (nxt_state == ST_INIT && state_ff == ST_INIT)
            nxt_cnt = (cnt_ff == {CNT_W{1'b1}}) ? cnt_ff : cnt_ff + 1'b1;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= ST_INIT;
            cnt_ff   <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Reports whether initialisation led the standby pin by the guard time
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            guard_ff  <= '0;
            ram_ok_ff <= 1'b0;
        end
        else
        begin
            if (chip_init_n)
                guard_ff <= '0;
            else if (guard_ff != {CNT_W{1'b1}})
                guard_ff <= guard_ff + 1'b1;
            if (!hw_sleep_pin_n && state_ff != ST_HWSTBY)
                ram_ok_ff <= (guard_ff >= CNT_W'(RAM_GUARD_CYC));
        end
    end

    assign addr_ok = (nxt_cnt >= CNT_W'(ADDR_INIT_CYC));
    assign clk_ok  = (nxt_cnt >= CNT_W'(CLK_INIT_CYC));

    // ************************************************************
    // Address-shared ports 5 and 6
    // ************************************************************
    always_comb
    begin
        role5 = ROLE_IO;
        role6 = ROLE_IO;
        if (mode == MODE_1 || mode == MODE_3)
            role5 = ROLE_ADDR;
        else if (mode == MODE_2 || mode == MODE_4)
            role5 = ROLE_SHARED;
        if (mode == MODE_3)
            role6 = ROLE_ADDR;
        else if (mode == MODE_4)
            role6 = ROLE_SHARED;
    end

    // Returns {oe, out, pullup} for one shared pin
    function automatic logic [2:0] pin_fn(psc_state_t st, psc_role_t role, logic ddr,
                                          logic dr, logic abit, logic aok);
        logic pu;
        pu = (st != ST_INIT) && (st != ST_HWSTBY) && (role != ROLE_ADDR)
             && !ddr && dr;
        pin_fn = {1'b0, 1'b0, pu};
        case (st)
            ST_INIT:
                pin_fn = {(role == ROLE_ADDR) && aok, 2'b00};
            ST_HWSTBY:
                pin_fn = 3'b000;
            ST_RUN:
                if (role == ROLE_ADDR || (role == ROLE_SHARED && ddr))
                    pin_fn = {1'b1, abit, 1'b0};
                else if (role == ROLE_IO)
                    pin_fn = {ddr, dr, pu};
            ST_SLEEP:
                if (role == ROLE_ADDR || (role == ROLE_SHARED && ddr))
                    pin_fn = 3'b100;
                else if (role == ROLE_IO)
                    pin_fn = {ddr, dr, pu};
            default:
                if (role == ROLE_IO)
                    pin_fn = {ddr, dr, pu};
        endcase
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < P5_W; gi++)
        begin : g_p5
            always_ff @(posedge core_clk or negedge rstn)
            begin
                if (!rstn)
                    {p5_oe[gi], p5_out[gi], p5_pullup[gi]} <= 3'b000;
                else
                    {p5_oe[gi], p5_out[gi], p5_pullup[gi]} <=
                        pin_fn(nxt_state, role5, port5_ff[PORT_DDR_LSB + gi],
                               port5_ff[PORT_DR_LSB + gi], core_addr[8 + gi], addr_ok);
            end
        end
        for (gi = 0; gi < P6_W; gi++)
        begin : g_p6
            always_ff @(posedge core_clk or negedge rstn)
            begin
                if (!rstn)
                    {p6_oe[gi], p6_out[gi], p6_pullup[gi]} <= 3'b000;
                else
                    {p6_oe[gi], p6_out[gi], p6_pullup[gi]} <=
                        pin_fn(nxt_state, role6, port6_ff[PORT_DDR_LSB + gi],
                               port6_ff[PORT_DR_LSB + gi], core_addr[16 + gi], addr_ok);
            end
        end
    endgenerate

    // ************************************************************
    // Bus strobes, low address, data bus and clock pins
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strobe_n      <= 4'hF;
            strobe_oe     <= 1'b0;
            rw_out        <= 1'b1;
            rw_oe         <= 1'b0;
            data_oe       <= 1'b0;
            addr_lo_out   <= 8'h00;
            addr_lo_oe    <= 1'b0;
            clk_pins_oe   <= 1'b0;
            clk_hold_high <= 1'b0;
        end
        else
        begin
            strobe_n    <= (nxt_state == ST_RUN) ? core_strobe_n : 4'hF;
            strobe_oe   <= ext_mode && (nxt_state == ST_INIT || nxt_state == ST_RUN
                                        || nxt_state == ST_SLEEP);
            data_oe     <= ext_mode && (nxt_state == ST_RUN) && core_data_oe;
            rw_out      <= (nxt_state == ST_RUN) ? core_rw : 1'b1;
            rw_oe       <= ext_mode && ((nxt_state == ST_INIT && addr_ok)
                                        || nxt_state == ST_RUN || nxt_state == ST_SLEEP);
            addr_lo_out <= (nxt_state == ST_RUN) ? core_addr[7:0] : 8'h00;
            addr_lo_oe  <= ext_mode && ((nxt_state == ST_INIT && addr_ok)
                                        || nxt_state == ST_RUN || nxt_state == ST_SLEEP);
            clk_pins_oe <= (nxt_state == ST_INIT) ? clk_ok :
                           (nxt_state != ST_HWSTBY);
            clk_hold_high <= (nxt_state == ST_SWSTBY);
        end
    end

    // ************************************************************
    // Grant, timer pin, peripheral reset and port enables
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            grant_out_n   <= 1'b1;
            grant_oe      <= 1'b0;
            timer_pin_out <= 1'b0;
            timer_pin_oe  <= 1'b0;
            periph_rst    <= 1'b1;
            ports_oe_en   <= 1'b0;
            p8_oe         <= 8'h00;
        end
        else
        begin
            grant_out_n  <= (nxt_state != ST_BUSREL);
            grant_oe     <= ctrl_ff[CTRL_GRANT_BIT] && ext_mode
                            && (nxt_state == ST_RUN || nxt_state == ST_SLEEP
                                || nxt_state == ST_BUSREL);
            if (nxt_state == ST_RUN && ctrl_ff[CTRL_TMREN_BIT])
            begin
                timer_pin_out <= timer_out;
                timer_pin_oe  <= 1'b1;
            end
            else
            begin
                timer_pin_out <= ctrl_ff[CTRL_TDR_BIT];
                timer_pin_oe  <= ctrl_ff[CTRL_TDDR_BIT] && nxt_state != ST_INIT
                                 && nxt_state != ST_HWSTBY;
            end
            periph_rst  <= (nxt_state == ST_INIT || nxt_state == ST_SWSTBY
                            || nxt_state == ST_HWSTBY);
            ports_oe_en <= (nxt_state != ST_INIT && nxt_state != ST_HWSTBY);
            p8_oe       <= 8'h00;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    init_float_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !chip_init_n && hw_sleep_pin_n |=> !ports_oe_en && !data_oe && (strobe_n == 4'hF)
        && (p5_oe & ~{P5_W{$past(addr_ok)}}) == '0)
        else $error("init did not float ports");
    init_strobe_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ext_mode && $stable(ctrl_ff) && !chip_init_n && hw_sleep_pin_n |=> strobe_oe)
        else $error("strobes not driven in init");
    addr_delay_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(state_ff == ST_INIT) && ext_mode && $stable(ctrl_ff)
        ##0 (!chip_init_n && hw_sleep_pin_n)[*3] |-> addr_lo_oe && rw_oe && rw_out
        && addr_lo_out == 8'h00 && !$past(addr_lo_oe) && $past(clk_pins_oe))
        else $error("address init delay wrong");
    clk_delay_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(state_ff == ST_INIT) ##1 (!chip_init_n && hw_sleep_pin_n) |-> clk_pins_oe)
        else $error("clock pins late");
    mode2_in_a: assert property (@(posedge core_clk) disable iff (!rstn)
        state_ff == ST_INIT && mode == MODE_2 |-> p5_oe == '0)
        else $error("mode 2 high address driven");
    pullup_rule_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $stable(port5_ff) && $stable(ctrl_ff) && !(state_ff inside {ST_INIT, ST_HWSTBY})
        && role5 != ROLE_ADDR |-> p5_pullup == (~port5_ff[7:0] & port5_ff[15:8]))
        else $error("pull-up state wrong");
    pullup_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        state_ff inside {ST_INIT, ST_HWSTBY} || $past(role5 == ROLE_ADDR) |-> p5_pullup == '0)
        else $error("pull-up on when forbidden");
    swstb_per_a: assert property (@(posedge core_clk) disable iff (!rstn)
        state_ff == ST_SWSTBY |-> periph_rst && !grant_oe && clk_pins_oe && clk_hold_high)
        else $error("standby peripheral state");
    grant_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
        state_ff == ST_BUSREL |-> !grant_out_n && grant_oe && !addr_lo_oe)
        else $error("grant not low in release");
    sleep_addr_a: assert property (@(posedge core_clk) disable iff (!rstn)
        state_ff == ST_SLEEP && $stable(ctrl_ff) && role5 == ROLE_ADDR |-> p5_oe == '1
        && p5_out == '0)
        else $error("sleep address not low");
    hwstby_a: assert property (@(posedge core_clk) disable iff (!rstn)
        state_ff == ST_HWSTBY |-> p5_oe == '0 && p6_oe == '0 && !strobe_oe
        && !addr_lo_oe && !clk_pins_oe && !timer_pin_oe)
        else $error("hardware standby drives pin");
    input_only_a: assert property (@(posedge core_clk) disable iff (!rstn)
        p8_oe == 8'h00)
        else $error("input-only port driven");

endmodule

// >>> shared/psc_pkg.sv
// Constants, register map and state encoding for the pin state controller
package psc_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] PSC_CTRL_OFS   = 8'h00;
    localparam logic [7:0] PSC_PORT5_OFS  = 8'h04;
    localparam logic [7:0] PSC_PORT6_OFS  = 8'h08;
    localparam logic [7:0] PSC_STATUS_OFS = 8'h0C;

    // Control register fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_MODE_W    = 3;
    localparam int CTRL_SLEEP_BIT = 4;
    localparam int CTRL_SWSTB_BIT = 5;
    localparam int CTRL_GRANT_BIT = 6;
    localparam int CTRL_TMREN_BIT = 7;
    localparam int CTRL_TDDR_BIT  = 8;
    localparam int CTRL_TDR_BIT   = 9;
    localparam logic [9:0] CTRL_RST = 10'h001;

    // Port registers: direction bits low byte, output latch bits next byte
    localparam int PORT_DDR_LSB = 0;
    localparam int PORT_DR_LSB  = 8;
    localparam int P5_W = 8;
    localparam int P6_W = 4;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_RAMOK_BIT = 8;

    // ************************************************************
    // Operating modes and pin roles
    // ************************************************************
    localparam logic [2:0] MODE_1 = 3'h1;
    localparam logic [2:0] MODE_2 = 3'h2;
    localparam logic [2:0] MODE_3 = 3'h3;
    localparam logic [2:0] MODE_4 = 3'h4;
    localparam logic [2:0] MODE_7 = 3'h7;

    typedef enum logic [1:0] {ROLE_ADDR = 2'h0, ROLE_SHARED = 2'h1, ROLE_IO = 2'h2} psc_role_t;

    typedef enum logic [5:0] {
        ST_INIT   = 6'h01,
        ST_HWSTBY = 6'h02,
        ST_RUN    = 6'h04,
        ST_SLEEP  = 6'h08,
        ST_SWSTBY = 6'h10,
        ST_BUSREL = 6'h20
    } psc_state_t;

    // ************************************************************
    // Timing, in half system clock periods and derived cycles
    // ************************************************************
    localparam int ADDR_INIT_HALF = 3;
    localparam int CLK_INIT_HALF  = 1;
    localparam int ADDR_INIT_CYC  = (ADDR_INIT_HALF + 1) / 2;
    localparam int CLK_INIT_CYC   = (CLK_INIT_HALF + 1) / 2;
    localparam int RAM_GUARD_CYC  = 10;
    localparam int CNT_W          = 4;

endpackage

// >>> testbench/psc_board.sv
// Board model: chip initialisation, hardware standby and bus request pins
`timescale 1ns/1ps
module psc_board
(
    input  wire logic core_clk,
    input  wire logic want_init,
    input  wire logic want_hw_sleep_pin_n,
    input  wire logic want_req,
    output logic      chip_init_n = 1'b1,
    output logic      hw_sleep_pin_n = 1'b1,
    output logic      bus_request_in = 1'b0
);
    logic [4:0] low_cnt_ff = 5'h00;

    always @(posedge core_clk)
    begin
        chip_init_n <= !(want_init || want_hw_sleep_pin_n);
        bus_request_in <= want_req;
        if (chip_init_n)
            low_cnt_ff <= 5'h00;
        else if (low_cnt_ff != 5'h1F)
            low_cnt_ff <= low_cnt_ff + 5'h01;
        // Standby pin falls only once initialisation has been low 11 counted cycles
        hw_sleep_pin_n <= !(want_hw_sleep_pin_n && low_cnt_ff >= 5'h0B);
    end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the pin state controller
`timescale 1ns/1ps
module testbench
    import psc_pkg::*;
;
    logic        core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        want_init = 1'b0, want_hw_sleep_pin_n = 1'b0, want_req = 1'b0, timer_out = 1'b0;
    logic        core_rw = 1'b0, core_data_oe = 1'b1, pready, pslverr, strobe_oe, rw_out, rw_oe;
    logic        data_oe, addr_lo_oe, clk_pins_oe, clk_hold_high, grant_out_n, grant_oe;
    logic        timer_pin_out, timer_pin_oe, periph_rst, ports_oe_en;
    logic        chip_init_n, hw_sleep_pin_n, bus_request_in, err;
    logic [7:0]  paddr = 8'h00, addr_lo_out, p5_out, p5_oe, p5_pullup, p8_oe;
    logic [3:0]  core_strobe_n = 4'h0, strobe_n, p6_out, p6_oe, p6_pullup;
    logic [19:0] core_addr = 20'hABCDE;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          n_mismatch = 0, samples_checked = 0;

    psc_board brd (.core_clk, .want_init, .want_hw_sleep_pin_n, .want_req, .chip_init_n, .hw_sleep_pin_n,
        .bus_request_in);
    psc_top uut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .chip_init_n, .hw_sleep_pin_n, .bus_request_in, .core_addr, .core_strobe_n,
        .core_rw, .core_data_oe, .timer_out, .strobe_n, .strobe_oe, .rw_out, .rw_oe, .data_oe,
        .addr_lo_out, .addr_lo_oe, .p5_out, .p5_oe, .p5_pullup, .p6_out, .p6_oe, .p6_pullup,
        .clk_pins_oe, .clk_hold_high, .grant_out_n, .grant_oe, .timer_pin_out, .timer_pin_oe,
        .periph_rst, .ports_oe_en, .p8_oe);

    initial
    begin
        forever #2.5 core_clk = !core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic edges(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // APB transfer; holds the request until pready is sampled high or 50 cycles pass
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        chk(pready, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_init(input logic v, input int n);
        @(posedge core_clk);
        want_init <= v;
        edges(n);
        @(negedge core_clk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_init_mode1;
        set_init(1'b1, 2);
        chk({ports_oe_en, p5_oe, p6_oe, p8_oe, data_oe}, 0);
        chk({strobe_n, strobe_oe, p5_pullup}, 13'h1F00);
        @(negedge core_clk);
        chk({clk_pins_oe, addr_lo_oe}, 2'h2);
        @(negedge core_clk);
        chk({addr_lo_oe, addr_lo_out, rw_oe, rw_out, p5_oe, p5_out}, 27'h403FF00);
        set_init(1'b0, 3);
        chk({strobe_n, data_oe, rw_out, addr_lo_out, p5_out}, 22'h02DEBC);
    endtask

    task automatic t_pullups;
        apb(1'b1, PSC_CTRL_OFS, 32'h2);
        apb(1'b1, PSC_PORT5_OFS, 32'hFF0F);
        apb(1'b1, PSC_PORT6_OFS, 32'h0A03);
        edges(2);
        @(negedge core_clk);
        chk({p5_pullup, p6_pullup, p6_oe, p6_out}, 20'hF083A);
        set_init(1'b1, 3);
        chk({p5_oe, p6_oe, p5_pullup, p6_pullup}, 0);
        set_init(1'b0, 3);
        apb(1'b1, PSC_CTRL_OFS, 32'h1);
        edges(2);
        @(negedge core_clk);
        chk(p5_pullup, 8'h00);
        apb(1'b1, PSC_CTRL_OFS, 32'h11);
        edges(2);
        @(negedge core_clk);
        chk({p5_oe, p5_out, p5_pullup, addr_lo_out}, 32'hFF00_0000);
    endtask

    task automatic t_swstby;
        apb(1'b1, PSC_PORT5_OFS, 32'hFF0F);
        apb(1'b1, PSC_CTRL_OFS, 32'h3E2);
        edges(2);
        @(negedge core_clk);
        chk({periph_rst, grant_oe, timer_pin_oe, timer_pin_out, clk_hold_high}, 5'h17);
        chk({p5_oe, p5_pullup}, 16'h00F0);
        apb(1'b0, PSC_STATUS_OFS, 32'h0);
        chk({err, rd[5:0]}, {1'b0, ST_SWSTBY});
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        set_init(1'b1, 3);
        set_init(1'b0, 3);
    endtask

    task automatic t_sleep_busrel;
        int n;
        apb(1'b1, PSC_PORT5_OFS, 32'hFF0F);
        apb(1'b1, PSC_CTRL_OFS, 32'h52);
        edges(2);
        @(negedge core_clk);
        chk({p5_oe, p5_out, addr_lo_out}, 24'h0F0000);
        @(posedge core_clk);
        want_req <= 1'b1;
        n = 0;
        while (grant_out_n !== 1'b0 && n < 10)
        begin
            @(negedge core_clk);
            n++;
        end
        chk({grant_out_n, grant_oe}, 2'h1);
        apb(1'b0, PSC_STATUS_OFS, 32'h0);
        chk(rd[5:0], ST_BUSREL);
        @(negedge core_clk);
        chk({grant_out_n, p5_oe, p5_pullup}, 17'h000F0);
        @(posedge core_clk);
        want_req <= 1'b0;
    endtask

    task automatic t_hwstby;
        int n;
        @(posedge core_clk);
        want_hw_sleep_pin_n <= 1'b1;
        n = 0;
        while (hw_sleep_pin_n !== 1'b0 && n < 40)
        begin
            @(posedge core_clk);
            n++;
        end
        edges(2);
        @(negedge core_clk);
        chk({p5_oe, p6_oe, p8_oe, strobe_oe, data_oe, addr_lo_oe, rw_oe}, 0);
        chk({grant_oe, timer_pin_oe, ports_oe_en, p5_pullup, p6_pullup}, 0);
        apb(1'b0, PSC_STATUS_OFS, 32'h0);
        chk({rd[8], rd[5:0]}, {1'b1, ST_HWSTBY});
        @(posedge core_clk);
        want_init <= 1'b1;
        want_hw_sleep_pin_n <= 1'b0;
        set_init(1'b0, 3);
    endtask

    task automatic close_out;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_mismatch++;
        $display("unexpected at %0t: run too long", $time);
        close_out();
    end

    initial
    begin
        edges(10);
        rstn <= 1'b1;
        edges(3);
        t_init_mode1();
        t_pullups();
        t_swstby();
        t_sleep_busrel();
        t_hwstby();
        close_out();
    end
endmodule
